// ===== hw/apb_top.sv
// Summary of operation
// (RULE_01) all-zero select output arms priority selection
// (RULE_02) select input picks highest pending priority
// (RULE_03) equal priority goes to chain-selected adapter
// (RULE_04) start bit 1.5 marks priority outbound
// (RULE_05) pending interrupt encoded as 3-bit priority
// (RULE_06) phase A: adapter one drives, two compares
// (RULE_07) not-high/not-equal latches hold until reset pulse
// (RULE_08) phase B: adapter two drives, one compares
// (RULE_09) end of phase D decides has-priority
// (RULE_10) sampling repeats; selection only on select
// (RULE_11) select input reports interrupt, type, adapter
// (RULE_12) initial status: bit 0.0 means normal
// (RULE_13) setup output loads mode, monitors, count
// (RULE_14) start output: inbound request, status reset
// (RULE_15) ETB/ETX stops service, raises status interrupt
// (RULE_16) status input bit 0.5 reports service stop
// (RULE_17) DLE then STX clears monitor latches
// (RULE_18) after DLE-STX monitor bits read zero
// (RULE_19) trailing DLE sets remember latch, bit 0.5
// (RULE_20) program restores remember bit on next setup
// (RULE_21) remembered DLE plus leading STX clears monitors
// (RULE_22) consecutive SYN treated as fill
// (RULE_23) SYN count reached ends service, interrupts
// (RULE_24) non-SYN character ends SYN monitoring
// (RULE_25) ascii mode ignores top bit; SYN codes
// (RULE_26) phases A-D in order, latches cleared first
`timescale 1ns/1ps
`default_nettype none
module apb_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic      [31:0] dat_o,
  input  wire logic        peer_present_i,
  input  wire logic        adapter_two_i,
  input  wire logic        sel_prev_i,
  input  wire logic [2:0]  prio_bus_i,
  output logic      [2:0]  prio_bus_o,
  output logic             prio_bus_oe_o,
  output logic             sel_next_o,
  output logic             selected_o,
  output logic             irq_req_o,
  input  wire logic        init_sel_i,
  input  wire logic [6:0]  init_flags_i,
  input  wire logic        out_done_i,
  input  wire logic        chan_valid_i,
  input  wire logic [7:0]  chan_data_i,
  output logic             chan_req_o
);
  logic             ack_q;
  logic [31:0]      dat_q;
  logic             ebm_q, emu_q, syn_mon_q, dle_rem_q;
  logic             asc_q, ebc_q, dle_q, first_q;
  logic [4:0]       lim_q, bcnt_q;
  logic [1:0]       syn_lim_q, syn_cnt_q;
  logic [3:0]       rptr_q;
  apb_pkg::apb_seq_t seq_q;
  logic             pout_q, init_q, ds_q, isel_q, stop_q;
  logic             prime_q, nh_q, ne_q, has_q, sel_q, nxt_q;
  logic             two_q, oe_q, pend_q;
  logic [2:0]       bus_q;
  apb_pkg::apb_ph_t ph_q, ph_d;
  logic [15:0]      mem_rd;
  logic             c_stx, c_etx, c_etb, c_dle, c_syn;

  // priority of the pending interrupt
  function automatic logic [2:0] prio_code(
    input logic ds, input logic isel,
    input apb_pkg::apb_seq_t sq, input logic po);
    logic [2:0] c;
    c = apb_pkg::PR_NONE;
    if (ds && sq == apb_pkg::SQ_OUTB && po) begin
      c = apb_pkg::PR_POUT;
    end else if (ds && sq == apb_pkg::SQ_OUTB) begin
      c = apb_pkg::PR_OUT;
    end else if (isel) begin
      c = apb_pkg::PR_ISEL;
    end else if (ds && sq == apb_pkg::SQ_INB) begin
      c = apb_pkg::PR_INB;
    end else if (ds) begin
      c = apb_pkg::PR_DS;
    end
    return c;
  endfunction : prio_code

  // bus decode: writes commit at the acknowledged edge
  wire logic req   = cyc_i & stb_i;
  wire logic wr_ok = req & we_i & ack_q & (&sel_i[1:0]);
  wire logic rd_go = req & ~we_i & ~ack_q;
  wire logic w67 = wr_ok & (adr_i == apb_pkg::A_OUT67);
  wire logic w62 = wr_ok & (adr_i == apb_pkg::A_OUT62);
  wire logic w6c = wr_ok & (adr_i == apb_pkg::A_OUT6C);
  wire logic r77 = rd_go & (adr_i == apb_pkg::A_IN77);
  wire logic r60 = rd_go & (adr_i == apb_pkg::A_IN60);
  wire logic r6d = rd_go & (adr_i == apb_pkg::A_IN6D);
  wire logic prime_hit = w67 && dat_i[15:0] == apb_pkg::OUT67_PRIME;
  wire logic st_out = w62 & dat_i[apb_pkg::B_OUTB];
  wire logic st_in  = w62 & dat_i[apb_pkg::B_INB]; // [RULE_14]
  wire logic ds_clr = w62 & dat_i[apb_pkg::B_RSTDS]; // [RULE_14]

  // inbound byte scanning
  wire logic take = chan_valid_i & init_q;
  wire logic last = bcnt_q == lim_q - apb_pkg::CNT_ONE;
  wire logic scan = take & ebm_q & emu_q;
  wire logic mon  = ebc_q | asc_q;
  wire logic lead = dle_q | (first_q & dle_rem_q); // [RULE_21]
  wire logic stx_hit = scan & mon & c_stx & lead; // [RULE_17]
  wire logic etx_hit = scan & mon & (c_etb | c_etx) & ~stx_hit;
  wire logic syn_go  = scan & syn_mon_q & c_syn; // [RULE_22]
  wire logic syn_end = syn_go && syn_cnt_q + apb_pkg::SYN_ONE == syn_lim_q;
  wire logic syn_brk = scan & syn_mon_q & ~c_syn; // [RULE_24]
  wire logic cnt_end = take & last;
  wire logic stop_ev = etx_hit | syn_end | cnt_end; // [RULE_15] [RULE_23]
  wire logic ob_end  = out_done_i & (seq_q == apb_pkg::SQ_OUTB);
  wire logic ds_set  = stop_ev | ob_end;
  wire logic pend    = ds_q | isel_q;

  // priority comparison wires
  wire logic [2:0] own = prio_code(ds_q, isel_q, seq_q, pout_q); // [RULE_05]
  wire logic cmp = (ph_q == apb_pkg::PH_A && two_q) // [RULE_06]
                 | (ph_q == apb_pkg::PH_B && !two_q); // [RULE_08]
  wire logic wins = pend & (~peer_present_i | (~nh_q & (ne_q | sel_prev_i))); // [RULE_03]
  wire logic wins_l = has_q | ~peer_present_i;
  wire logic sel_new = prime_q ? wins_l : sel_q;
  wire logic drv = (ph_d == apb_pkg::PH_A && !two_q) || (ph_d == apb_pkg::PH_B && two_q);

  apb_char_dec u_dec (
    .byte_i  (chan_data_i),
    .ascii_i (asc_q),
    .stx_o   (c_stx),
    .etx_o   (c_etx),
    .etb_o   (c_etb),
    .dle_o   (c_dle),
    .syn_o   (c_syn)
  );

  apb_buf_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (take & ebm_q),
    .be_i    ({~bcnt_q[0], bcnt_q[0]}),
    .waddr_i (bcnt_q[4:1]),
    .wdata_i (chan_data_i),
    .raddr_i (rptr_q),
    .rdata_o (mem_rd)
  );

  // read data mux
  logic [15:0] rd_d;
  always_comb begin
    rd_d = 16'h0000;
    unique case (adr_i)
      apb_pkg::A_IN77: begin
        rd_d[apb_pkg::B_IRQ] = pend; // [RULE_11]
        rd_d[apb_pkg::B_DS] = ds_q;
        rd_d[apb_pkg::B_IS] = isel_q; // [RULE_11]
        rd_d[apb_pkg::B_ID] = sel_new ? two_q : ~two_q; // [RULE_11]
      end
      apb_pkg::A_IN62: begin
        rd_d[apb_pkg::B_OUTB]  = seq_q == apb_pkg::SQ_OUTB;
        rd_d[apb_pkg::B_INB]   = seq_q == apb_pkg::SQ_INB;
        rd_d[apb_pkg::B_SSTOP] = stop_q; // [RULE_16]
      end
      apb_pkg::A_IN6C: begin
        rd_d[apb_pkg::B_EBM]  = ebm_q;
        rd_d[apb_pkg::B_EMU]  = emu_q;
        rd_d[apb_pkg::B_SYN]  = syn_mon_q;
        rd_d[apb_pkg::B_DLER] = dle_rem_q; // [RULE_19]
        rd_d[apb_pkg::B_ASC]  = asc_q; // [RULE_18]
        rd_d[apb_pkg::B_EBC]  = ebc_q; // [RULE_18]
        rd_d[apb_pkg::F_CNT_LSB +: 5] = bcnt_q;
      end
      apb_pkg::A_IN60: begin
        rd_d[apb_pkg::B_OUTB] = isel_q; // [RULE_12]
        rd_d[apb_pkg::F_FLG_LSB +: 7] = init_flags_i; // [RULE_12]
      end
      apb_pkg::A_IN6D: rd_d = mem_rd;
      default: rd_d = 16'h0000;
    endcase
  end

  // wishbone answer: ack one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (rd_go) begin
        dat_q <= {16'h0000, rd_d};
      end
    end
  end

  // setup and monitor latches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ebm_q <= 1'b0;
      emu_q <= 1'b0;
      syn_mon_q <= 1'b0;
      dle_rem_q <= 1'b0;
      asc_q <= 1'b0;
      ebc_q <= 1'b0;
      dle_q <= 1'b0;
      lim_q <= 5'h00;
    end else if (w6c) begin
      ebm_q <= dat_i[apb_pkg::B_EBM]; // [RULE_13]
      emu_q <= dat_i[apb_pkg::B_EMU];
      syn_mon_q <= dat_i[apb_pkg::B_SYN]; // [RULE_13]
      dle_rem_q <= dat_i[apb_pkg::B_DLER]; // [RULE_20]
      asc_q <= dat_i[apb_pkg::B_ASC];
      ebc_q <= dat_i[apb_pkg::B_EBC]; // [RULE_13]
      dle_q <= 1'b0;
      lim_q <= dat_i[apb_pkg::F_CNT_LSB +: 5]; // [RULE_13]
    end else begin
      if (stx_hit) begin
        ebc_q <= 1'b0; // [RULE_17] [RULE_21]
        asc_q <= 1'b0;
        dle_q <= 1'b0;
      end else if (scan && mon) begin
        dle_q <= c_dle;
      end
      if (syn_brk) begin
        syn_mon_q <= 1'b0; // [RULE_24]
      end
      if (cnt_end && scan && mon && c_dle) begin
        dle_rem_q <= 1'b1; // [RULE_19]
      end
    end
  end

  // byte and read counters, reset by setup output
  always_ff @(posedge clk_i) begin
    if (rst_i || w6c) begin
      bcnt_q <= 5'h00; // [RULE_13]
      rptr_q <= 4'h0;
    end else begin
      if (take) begin
        bcnt_q <= bcnt_q + apb_pkg::CNT_ONE;
      end
      if (r6d) begin
        rptr_q <= rptr_q + apb_pkg::PTR_ONE;
      end
    end
  end

  // SYN fill counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      syn_cnt_q <= 2'h0;
      syn_lim_q <= 2'h0;
    end else if (w62) begin
      syn_cnt_q <= 2'h0;
      syn_lim_q <= dat_i[apb_pkg::F_SYN_LSB +: 2];
    end else if (syn_brk) begin
      syn_cnt_q <= 2'h0;
    end else if (syn_go) begin
      syn_cnt_q <= syn_cnt_q + apb_pkg::SYN_ONE; // [RULE_22]
    end
  end

  // sequence state and interrupt sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q <= apb_pkg::SQ_NONE;
      pout_q <= 1'b0;
      init_q <= 1'b0;
      ds_q <= 1'b0;
      isel_q <= 1'b0;
      stop_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      if (st_out) begin
        seq_q <= apb_pkg::SQ_OUTB;
        pout_q <= dat_i[apb_pkg::B_PRIO]; // [RULE_04]
      end else if (st_in) begin
        seq_q <= apb_pkg::SQ_INB;
        pout_q <= 1'b0;
      end
      if (stop_ev) begin
        init_q <= 1'b0; // [RULE_15] [RULE_23]
      end else if (st_in) begin
        init_q <= 1'b1;
      end
      ds_q <= ds_set | (ds_q & ~ds_clr); // [RULE_15]
      isel_q <= init_sel_i | (isel_q & ~r60);
      stop_q <= etx_hit | (stop_q & ~(st_in | st_out)); // [RULE_15]
      first_q <= st_in | (first_q & ~take);
    end
  end

  // sample phases in fixed order
  always_comb begin
    unique case (ph_q)
      apb_pkg::PH_RST: ph_d = apb_pkg::PH_A; // [RULE_26]
      apb_pkg::PH_A:   ph_d = apb_pkg::PH_B;
      apb_pkg::PH_B:   ph_d = apb_pkg::PH_C;
      apb_pkg::PH_C:   ph_d = apb_pkg::PH_D;
      apb_pkg::PH_D:   ph_d = apb_pkg::PH_RST; // [RULE_10]
      default:         ph_d = apb_pkg::PH_RST;
    endcase
  end

  // priority compare, decision and selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q <= apb_pkg::PH_RST;
      two_q <= 1'b0;
      nh_q <= 1'b0;
      ne_q <= 1'b0;
      has_q <= 1'b0;
      nxt_q <= 1'b0;
      prime_q <= 1'b0;
      sel_q <= 1'b0;
      oe_q <= 1'b0;
      bus_q <= 3'h0;
    end else begin
      ph_q <= ph_d;
      two_q <= adapter_two_i;
      oe_q <= drv; // [RULE_06] [RULE_08]
      bus_q <= drv ? own : 3'h0;
      if (ph_q == apb_pkg::PH_RST) begin
        nh_q <= 1'b0; // [RULE_07] [RULE_26]
        ne_q <= 1'b0;
      end else if (cmp) begin
        nh_q <= nh_q | (prio_bus_i > own); // [RULE_07]
        ne_q <= ne_q | (prio_bus_i != own);
      end
      if (ph_q == apb_pkg::PH_D) begin
        has_q <= wins; // [RULE_09]
        nxt_q <= sel_prev_i & ~wins;
      end
      if (prime_hit) begin
        prime_q <= 1'b1; // [RULE_01]
      end else if (r77) begin
        prime_q <= 1'b0;
      end
      if (r77 && prime_q) begin
        sel_q <= wins_l; // [RULE_02] [RULE_10]
      end
    end
  end

  // registered outputs
  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign prio_bus_o = bus_q;
  assign prio_bus_oe_o = oe_q;
  assign sel_next_o = nxt_q;
  assign selected_o = sel_q;
  assign irq_req_o = pend_q;
  assign chan_req_o = init_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bcd;
    ph_q == apb_pkg::PH_B ##1 ph_q == apb_pkg::PH_C ##1 ph_q == apb_pkg::PH_D;
  endsequence

  chk_prime_arm: assert property (prime_hit |=> prime_q) // [RULE_01]
    else $error("prime latch not set");
  chk_select_take: assert property (r77 && prime_q && has_q |=> sel_q) // [RULE_02]
    else $error("selection not taken");
  chk_select_hold: assert property (!r77 |=> $stable(sel_q)) // [RULE_10]
    else $error("selection changed without select");
  chk_latch_sticky: assert property (nh_q && ph_q != apb_pkg::PH_RST |=> nh_q) // [RULE_07]
    else $error("not-high latch dropped");
  chk_phase_order: assert property (ph_q == apb_pkg::PH_A |=> s_bcd ##1 ph_q == apb_pkg::PH_RST) // [RULE_26]
    else $error("phase order broken");
  chk_one_drives: assert property (ph_q == apb_pkg::PH_A && !$past(two_q) |-> prio_bus_oe_o) // [RULE_06]
    else $error("adapter one not driving at A");
  chk_stop_ends: assert property (etx_hit |=> stop_q && !init_q && ds_q) // [RULE_15]
    else $error("end character did not stop");
  chk_dle_stx: assert property (stx_hit && !w6c |=> !ebc_q && !asc_q && !dle_q) // [RULE_17]
    else $error("monitors not cleared");
  chk_syn_break: assert property (syn_brk && !w6c |=> !syn_mon_q) // [RULE_24]
    else $error("syn monitor kept");
endmodule : apb_top
`default_nettype wire

// ===== hw/apb_pkg.sv
package apb_pkg;
  // register byte offsets
  localparam logic [7:0] A_OUT67 = 8'h00;
  localparam logic [7:0] A_OUT62 = 8'h04;
  localparam logic [7:0] A_OUT6C = 8'h08;
  localparam logic [7:0] A_IN77  = 8'h0c;
  localparam logic [7:0] A_IN62  = 8'h10;
  localparam logic [7:0] A_IN6C  = 8'h14;
  localparam logic [7:0] A_IN60  = 8'h18;
  localparam logic [7:0] A_IN6D  = 8'h1c;
  // bit positions: bit 0.n is 15-n, bit 1.n is 7-n
  localparam int B_OUTB  = 15;
  localparam int B_EBM   = 15;
  localparam int B_INB   = 14;
  localparam int B_EMU   = 13;
  localparam int B_SYN   = 11;
  localparam int B_DLER  = 10;
  localparam int B_SSTOP = 10;
  localparam int B_ASC   = 9;
  localparam int B_RSTDS = 9;
  localparam int B_EBC   = 8;
  localparam int B_IRQ   = 7;
  localparam int B_DS    = 4;
  localparam int B_IS    = 3;
  localparam int B_PRIO  = 2;
  localparam int B_ID    = 1;
  localparam int F_CNT_LSB = 0;
  localparam int F_SYN_LSB = 0;
  localparam int F_FLG_LSB = 8;
  // priority codes, weights 4 2 1
  localparam logic [2:0] PR_POUT = 3'h7;
  localparam logic [2:0] PR_OUT  = 3'h6;
  localparam logic [2:0] PR_ISEL = 3'h5;
  localparam logic [2:0] PR_INB  = 3'h4;
  localparam logic [2:0] PR_DS   = 3'h3;
  localparam logic [2:0] PR_NONE = 3'h0;
  // control characters
  localparam logic [7:0] C_STX   = 8'h02;
  localparam logic [7:0] C_ETX   = 8'h03;
  localparam logic [7:0] C_DLE   = 8'h10;
  localparam logic [7:0] C_SYN_E = 8'h32;
  localparam logic [7:0] C_SYN_A = 8'h16;
  localparam logic [7:0] C_ETB_E = 8'h26;
  localparam logic [7:0] C_ETB_A = 8'h17;
  localparam logic [15:0] OUT67_PRIME = 16'h0000;
  localparam logic [4:0]  CNT_ONE = 5'h01;
  localparam logic [1:0]  SYN_ONE = 2'h1;
  localparam logic [3:0]  PTR_ONE = 4'h1;
  typedef enum logic [2:0] {PH_RST, PH_A, PH_B, PH_C, PH_D} apb_ph_t;
  typedef enum logic [1:0] {SQ_NONE, SQ_OUTB, SQ_INB} apb_seq_t;
endpackage : apb_pkg

// ===== hw/apb_char_dec.sv
`timescale 1ns/1ps
`default_nettype none
// classifies one channel byte as a control character
module apb_char_dec (
  input  wire logic [7:0] byte_i,
  input  wire logic       ascii_i,
  output logic            stx_o,
  output logic            etx_o,
  output logic            etb_o,
  output logic            dle_o,
  output logic            syn_o
);
  // ascii mode masks channel bit 0, the top bit
  wire logic [7:0] msk = ascii_i ? 8'h7f : 8'hff; // [RULE_25]
  wire logic [7:0] b   = byte_i & msk;
  wire logic [7:0] syn = ascii_i ? apb_pkg::C_SYN_A : apb_pkg::C_SYN_E;
  wire logic [7:0] etb = ascii_i ? apb_pkg::C_ETB_A : apb_pkg::C_ETB_E;
  // matches
  assign stx_o = b == apb_pkg::C_STX;
  assign etx_o = b == apb_pkg::C_ETX;
  assign etb_o = b == etb;
  assign dle_o = b == apb_pkg::C_DLE;
  assign syn_o = b == syn; // [RULE_25]
endmodule : apb_char_dec
`default_nettype wire

// ===== hw/apb_buf_mem.sv
`timescale 1ns/1ps
`default_nettype none
// 16 x 16 local store, byte writes, registered read
module apb_buf_mem (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [1:0]  be_i,
  input  wire logic [3:0]  waddr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [3:0]  raddr_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] mem_q [16];
  // byte lane 1 is the high byte (byte 0 of the pair)
  always_ff @(posedge clk_i) begin
    if (we_i && be_i[1]) begin
      mem_q[waddr_i][15:8] <= wdata_i;
    end
    if (we_i && be_i[0]) begin
      mem_q[waddr_i][7:0] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule : apb_buf_mem
`default_nettype wire

// ===== test/apb_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// peer adapter two on the shared priority bus
module apb_peer_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       own_oe_i,
  input  wire logic [2:0] code_i,
  output logic      [2:0] prio_bus_o,
  output logic            drive_o
);
  logic [2:0] last_q;

  // answer in the phase right after adapter one's slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_o <= 1'b0;
      last_q  <= 3'h0;
    end else begin
      drive_o <= own_oe_i;
      if (drive_o) begin
        last_q <= code_i; // remember the code last driven
      end
    end
  end

  // a released bus must not keep the last code, so it shows its inverse
  assign prio_bus_o = drive_o ? code_i : ~last_q;
endmodule : apb_peer_model
`default_nettype wire

// ===== test/test_apb_top.sv
`timescale 1ns/1ps
`default_nettype none
// wishbone master, channel source and peer adapter around the top
module test_apb_top;
  logic        clk_i, rst_i, cyc, stb, we, peer_on, sel_prev, init_sel, out_done, cv;
  logic        ack, oe, peer_drv, sel_nx, selected, irq, chreq;
  logic [7:0]  adr, cd;
  logic [31:0] wdat, rdat;
  logic [6:0]  flags;
  logic [3:0]  sel;
  logic [2:0]  peer_code, dut_bus, peer_bus, bus_w, pc [5];
  logic [15:0] q, ctl, w62 [5];
  logic [7:0]  stops [4];
  logic        dn [5];
  int          n_mismatch, compares, cycles;

  // wire level of the priority bus: the dut's code while oe is set, otherwise the peer's
  assign bus_w = oe ? dut_bus : peer_bus;

  apb_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .ack_o(ack), .dat_o(rdat), .peer_present_i(peer_on),
    .adapter_two_i(1'b0), .sel_prev_i(sel_prev), .prio_bus_i(bus_w), .prio_bus_o(dut_bus),
    .prio_bus_oe_o(oe), .sel_next_o(sel_nx), .selected_o(selected), .irq_req_o(irq),
    .init_sel_i(init_sel), .init_flags_i(flags), .out_done_i(out_done), .chan_valid_i(cv),
    .chan_data_i(cd), .chan_req_o(chreq));

  apb_peer_model i_peer (.clk_i(clk_i), .rst_i(rst_i), .own_oe_i(oe), .code_i(peer_code),
    .prio_bus_o(peer_bus), .drive_o(peer_drv));

  task automatic chk_reg(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_reg

  task automatic chk_pin(input string nm, input logic [2:0] exp, input logic [2:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_pin

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask : tick

  // one classic cycle; read data is taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // ack must come exactly one cycle after the request is seen
    chk_pin("ack_latency", 3'h2, (n > 7) ? 3'h7 : n[2:0]);
  endtask : wb

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 16'h0000);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask : wr

  // one inbound byte offered for a single cycle
  task automatic put(input logic [7:0] b);
    @(posedge clk_i);
    cv <= 1'b1;
    cd <= b;
    @(posedge clk_i);
    cv <= 1'b0;
  endtask : put

  // setup then start inbound, clearing the data/status interrupt
  task automatic inb(input logic [15:0] c, input logic [1:0] syn);
    wr(apb_pkg::A_OUT6C, c);
    wr(apb_pkg::A_OUT62, {14'h1080, syn});
  endtask : inb

  task automatic bus_code(input logic [2:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (oe !== 1'b1 && n < 20);
    chk_pin("prio_bus", exp, dut_bus);
  endtask : bus_code

  // cut a hang short
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, cyc, stb, we, peer_on, sel_prev, init_sel, out_done, cv} = 9'h100;
    {adr, cd, wdat, flags, peer_code, cycles} = '0;
    sel = 4'hf;
    n_mismatch = 0;
    compares = 0;
    stops = '{apb_pkg::C_ETB_E, apb_pkg::C_ETX, apb_pkg::C_ETB_A | 8'h80, apb_pkg::C_ETX | 8'h80};
    w62 = '{16'h0200, 16'h8004, 16'h8200, 16'h4200, 16'h0200};
    pc = '{apb_pkg::PR_NONE, apb_pkg::PR_POUT, apb_pkg::PR_OUT, apb_pkg::PR_INB, apb_pkg::PR_NONE};
    dn = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_pin("chan_req", 3'h0, {2'h0, chreq});
    rd(8'h20);
    chk_reg("unmapped", 16'h0000, q);
    // a write without both low byte lanes is acknowledged but ignored
    sel <= 4'h0;
    wr(apb_pkg::A_OUT6C, 16'hffff);
    sel <= 4'hf;
    rd(apb_pkg::A_IN6C);
    chk_reg("in6c_refused", 16'h0000, q);
    $display("test reset done");
    // ending characters in both alphabets, top bit set in ascii
    for (int i = 0; i < 4; i++) begin
      ctl = (i < 2) ? 16'ha108 : 16'ha208;
      inb(ctl, 2'h0);
      tick(1);
      chk_pin("chan_req", 3'h1, {2'h0, chreq});
      put(8'h41);
      put(stops[i]);
      tick(3);
      chk_pin("chan_req", 3'h0, {2'h0, chreq});
      chk_pin("irq", 3'h1, {2'h0, irq});
      rd(apb_pkg::A_IN62);
      chk_reg("in62", 16'h0400, q & 16'h0400);
      rd(apb_pkg::A_IN6C);
      chk_reg("in6c", {ctl[15:8], 8'h02}, q);
      rd(apb_pkg::A_IN77);
      chk_reg("in77", 16'h0090, q & 16'h0098);
      rd(apb_pkg::A_IN6D);
      chk_reg("store", {8'h41, stops[i]}, q);
    end
    $display("test stop done");
    // transparent data after dle-stx is not scanned
    inb(16'ha304, 2'h0);
    put(apb_pkg::C_DLE);
    put(apb_pkg::C_STX);
    rd(apb_pkg::A_IN6C);
    chk_reg("in6c", 16'h2000, q & 16'h2700);
    put(apb_pkg::C_ETX);
    tick(3);
    chk_pin("chan_req", 3'h1, {2'h0, chreq});
    put(8'h41);
    tick(3);
    chk_pin("chan_req", 3'h0, {2'h0, chreq});
    // trailing dle remembered, then leading stx
    inb(16'ha102, 2'h0);
    put(8'h41);
    put(apb_pkg::C_DLE);
    tick(3);
    rd(apb_pkg::A_IN6C);
    chk_reg("in6c", 16'h0400, q & 16'h0400);
    inb(16'ha502, 2'h0);
    put(apb_pkg::C_STX);
    rd(apb_pkg::A_IN6C);
    chk_reg("in6c", 16'h0000, q & 16'h0300);
    $display("test dle done");
    // sync fill up to the programmed count
    inb(16'ha908, 2'h2);
    put(apb_pkg::C_SYN_E);
    put(apb_pkg::C_SYN_E);
    tick(3);
    chk_pin("chan_req", 3'h0, {2'h0, chreq});
    inb(16'ha908, 2'h2);
    put(apb_pkg::C_SYN_E);
    put(8'h41);
    rd(apb_pkg::A_IN6C);
    chk_reg("in6c", 16'h0000, q & 16'h0800);
    put(apb_pkg::C_SYN_E);
    tick(3);
    chk_pin("chan_req", 3'h1, {2'h0, chreq});
    put(apb_pkg::C_ETX);
    tick(3);
    chk_pin("chan_req", 3'h0, {2'h0, chreq});
    wr(apb_pkg::A_OUT62, 16'h0200);
    $display("test syn done");
    // priority selection against the peer
    flags <= 7'h05;
    init_sel <= 1'b1;
    tick(1);
    init_sel <= 1'b0;
    tick(2);
    chk_pin("irq", 3'h1, {2'h0, irq});
    bus_code(apb_pkg::PR_ISEL);
    wr(apb_pkg::A_OUT67, 16'h0000);
    rd(apb_pkg::A_IN77);
    tick(1);
    chk_pin("selected", 3'h1, {2'h0, selected});
    peer_on <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      peer_code <= (i == 0) ? 3'h7 : ((i == 1) ? 3'h3 : 3'h5);
      sel_prev <= (i == 3);
      tick(12);
      wr(apb_pkg::A_OUT67, apb_pkg::OUT67_PRIME);
      rd(apb_pkg::A_IN77);
      chk_reg("in77", 16'h0088, q & 16'h0088);
      tick(1);
      chk_pin("selected", {2'h0, i[0]}, {2'h0, selected});
    end
    peer_code <= 3'h7;
    tick(12);
    rd(apb_pkg::A_IN77);
    tick(1);
    chk_pin("selected", 3'h1, {2'h0, selected});
    chk_pin("sel_next", 3'h1, {2'h0, sel_nx});
    wr(apb_pkg::A_OUT67, 16'h0040);
    rd(apb_pkg::A_IN77);
    tick(1);
    chk_pin("selected", 3'h1, {2'h0, selected});
    rd(apb_pkg::A_IN60);
    chk_reg("in60", 16'h8500, q);
    rd(apb_pkg::A_IN60);
    chk_reg("in60", 16'h0500, q);
    $display("test select done");
    // priority code for no, priority outbound, outbound and inbound pending interrupts
    for (int i = 0; i < 5; i++) begin
      wr(apb_pkg::A_OUT62, w62[i]);
      out_done <= dn[i];
      tick(1);
      out_done <= 1'b0;
      put(apb_pkg::C_ETX);
      tick(6);
      bus_code(pc[i]);
    end
    $display("test codes done");
    end_of_test();
  end
endmodule : test_apb_top
`default_nettype wire
